// ==== rtl/print_scan_pkg.sv ====
// Constants shared by the print and scan drive logic.
// Assumes a 20 MHz system clock (mclk) and a separate scanner link clock.
package print_scan_pkg;

  // ----------------------------------------------------------------
  // Head geometry
  // ----------------------------------------------------------------
  localparam int unsigned CHIPS_PER_HEAD = 9;
  localparam int unsigned DOTS_PER_CHIP  = 192;
  localparam int unsigned DOTS_PER_LINE  = CHIPS_PER_HEAD * DOTS_PER_CHIP;
  localparam int unsigned DOT_CNT_W      = 11;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned LINE_PERIOD_US  = 9216;
  localparam int unsigned LINE_PERIOD_CYC = LINE_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SHIFT_HALF_CYC  = 2;
  localparam int unsigned LATCH_CYC       = 4;
  // Step periods in mclk cycles for 217, 108.5 and 434 pps
  localparam int unsigned STEP_217_CYC    = CLK_HZ / 217;
  localparam int unsigned STEP_108_CYC    = (CLK_HZ * 2) / 217;
  localparam int unsigned STEP_434_CYC    = CLK_HZ / 434;
  localparam int unsigned STEP_UM         = 130;
  localparam int unsigned TIMER_W         = 24;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_STD        = 3'h0;
  localparam logic [2:0] MODE_FINE       = 3'h1;
  localparam logic [2:0] MODE_HALFTONE   = 3'h2;
  localparam logic [2:0] MODE_SUPERFINE  = 3'h3;
  localparam logic [2:0] MODE_PAPER_FEED = 3'h4;

  // Scan pitch per resolution, lines per mm times 100
  localparam int unsigned PITCH_STD_X100  = 358;
  localparam int unsigned PITCH_FINE_X100 = 770;
  localparam int unsigned PITCH_SF_X100   = 1540;

  localparam int unsigned SAMPLE_W   = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned STROBE_W   = 16;

endpackage

// ==== rtl/thermal_print_and_scan_drive.sv ====
// Print and scan drive: head shift/latch/strobe, motor phasing, scanner capture.
// Assumes a 20 MHz mclk, a scanner link clock of its own, synchronous high reset.
`timescale 1ns/1ps


// ------------------------------------------------------------------
// Line FIFO
// ------------------------------------------------------------------
module dot_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             full;
  logic             empty;

  // Full when pointers differ only in the wrap bit
  assign full      = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty     = (wr_q == rd_q);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_q[AW-1:0]];

  // Storage write
  always_ff @(posedge mclk) begin
    if (in_valid && !full) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (in_valid && !full) wr_q <= wr_q + 1'b1;
      if (out_ready && !empty) rd_q <= rd_q + 1'b1;
    end
  end
endmodule // dot_fifo

// ------------------------------------------------------------------
// Top level
// ------------------------------------------------------------------
module thermal_print_and_scan_drive (
  input  wire logic       mclk,
  input  wire logic       reset,
  // Print line source
  input  wire logic       print_dot,
  input  wire logic       print_dot_valid,
  output logic            print_dot_ready,
  input  wire logic       print_enable,
  input  wire logic [7:0] thermistor_code,
  // Head pins
  output logic            head_shift_clock,
  output logic            head_serial_dot,
  output logic            head_line_latch,
  output logic            head_power_enable,
  output logic            head_strobe_a,
  output logic            head_strobe_b,
  output logic            line_printed,
  // Motor
  input  wire logic [2:0] motor_mode,
  input  wire logic       motor_run,
  input  wire logic       mode_change,
  input  wire logic       cam_home_switch,
  output logic            motor_power_enable,
  output logic [3:0]      motor_phase,
  output logic            motor_ccw,
  output logic            cam_at_home,
  // Scanner
  input  wire logic       scan_clk,
  input  wire logic       original_inserted,
  input  wire logic       start_request,
  input  wire logic       scan_active,
  input  wire logic       shading_capture,
  input  wire logic [7:0] scanner_analog_input,
  input  wire logic       scanner_sample_valid,
  output logic            scanner_light_enable,
  output logic [2:0]      sensor_drive_pulses,
  output logic            scan_dot,
  output logic            scan_dot_valid,
  output logic [10:0]     scan_pitch_x100
);

  // ----------------------------------------------------------------
  // Dot FIFO between source and head shifter
  // ----------------------------------------------------------------
  logic fifo_dot;
  logic fifo_valid;
  logic fifo_pop;

  dot_fifo #(.WIDTH(1), .DEPTH(print_scan_pkg::FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .reset     (reset),
    .in_data   (print_dot),
    .in_valid  (print_dot_valid),
    .in_ready  (print_dot_ready),
    .out_data  (fifo_dot),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop)
  );

  // ----------------------------------------------------------------
  // Head sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_LOW   = 3'b001,
    HS_HIGH  = 3'b011,
    HS_LATCH = 3'b010,
    HS_WAIT  = 3'b110
  } head_state_t;

  head_state_t  head_q;
  logic [10:0]  dot_cnt_q;
  logic [2:0]   phase_cnt_q;
  logic [23:0]  line_tmr_q;
  logic [15:0]  strobe_cnt_q;
  logic         strobe_sel_q;
  logic [15:0]  strobe_width;

  // Pop happens as the dot is loaded onto the serial line, one cycle before the rising shift edge is issued
  assign fifo_pop = (head_q == HS_LOW) && fifo_valid &&
                    (phase_cnt_q == 3'(print_scan_pkg::SHIFT_HALF_CYC - 1));

  // Strobe width table, hotter head gets shorter pulse
  always_comb begin
    unique case (thermistor_code[7:6])
      2'h0:    strobe_width = 16'h2EE0;
      2'h1:    strobe_width = 16'h2710;
      2'h2:    strobe_width = 16'h1F40;
      default: strobe_width = 16'h1770;
    endcase
  end

  // Shift, latch and line timing
  always_ff @(posedge mclk) begin
    if (reset) begin
      head_q           <= HS_IDLE;
      dot_cnt_q        <= '0;
      phase_cnt_q      <= '0;
      head_shift_clock <= 1'b0;
      head_serial_dot  <= 1'b0;
      head_line_latch  <= 1'b0;
      line_tmr_q       <= '0;
      line_printed     <= 1'b0;
    end else begin
      line_printed <= 1'b0;
      if (line_tmr_q != '0) line_tmr_q <= line_tmr_q - 1'b1;
      unique case (head_q)
        HS_IDLE: begin
          if (print_enable) head_q <= HS_LOW;
        end
        HS_LOW: begin
          // Data changes with clock low, so it is settled at the rise
          head_shift_clock <= 1'b0;
          if (fifo_valid) begin
            if (phase_cnt_q == 3'(print_scan_pkg::SHIFT_HALF_CYC - 1)) begin
              head_serial_dot <= fifo_dot;
              phase_cnt_q     <= '0;
              head_q          <= HS_HIGH;
            end else begin
              phase_cnt_q <= phase_cnt_q + 1'b1;
            end
          end
        end
        HS_HIGH: begin
          head_shift_clock <= 1'b1;
          if (phase_cnt_q == 3'(print_scan_pkg::SHIFT_HALF_CYC - 1)) begin
            phase_cnt_q <= '0;
            if (dot_cnt_q == 11'(print_scan_pkg::DOTS_PER_LINE - 1)) begin
              dot_cnt_q <= '0;
              head_q    <= HS_LATCH;
            end else begin
              dot_cnt_q <= dot_cnt_q + 1'b1;
              head_q    <= HS_LOW;
            end
          end else begin
            phase_cnt_q <= phase_cnt_q + 1'b1;
          end
        end
        HS_LATCH: begin
          // Latch at the earliest on the same edge the last clock falls; waits for previous line time
          head_shift_clock <= 1'b0;
          if (line_tmr_q == '0 && strobe_cnt_q == '0) begin
            head_line_latch <= 1'b1;
            // Pulse stands a full LATCH_CYC cycles before it drops
            if (phase_cnt_q == 3'(print_scan_pkg::LATCH_CYC)) begin
              head_line_latch <= 1'b0;
              phase_cnt_q     <= '0;
              line_tmr_q      <= 24'(print_scan_pkg::LINE_PERIOD_CYC);
              head_q          <= HS_WAIT;
            end else begin
              phase_cnt_q <= phase_cnt_q + 1'b1;
            end
          end
        end
        HS_WAIT: begin
          line_printed <= 1'b1;
          head_q       <= print_enable ? HS_LOW : HS_IDLE;
        end
        default: head_q <= HS_IDLE;
      endcase
    end
  end

  // Head power only while printing or a strobe is still owed; the line wait is powered whenever print_enable is high
  always_ff @(posedge mclk) begin
    if (reset) head_power_enable <= 1'b0;
    else       head_power_enable <= print_enable || (strobe_cnt_q != '0);
  end

  // Two strobe blocks fired in turn inside each line period
  always_ff @(posedge mclk) begin
    if (reset) begin
      strobe_cnt_q  <= '0;
      strobe_sel_q  <= 1'b0;
      head_strobe_a <= 1'b0;
      head_strobe_b <= 1'b0;
    end else begin
      head_strobe_a <= 1'b0;
      head_strobe_b <= 1'b0;
      if (head_q == HS_WAIT) begin
        strobe_cnt_q <= strobe_width;
        strobe_sel_q <= 1'b0;
      end else if (strobe_cnt_q != '0) begin
        // Chips gate strobe by latched bit no strobe without power
        if (head_power_enable && !head_line_latch) begin
          head_strobe_a <= !strobe_sel_q;
          head_strobe_b <= strobe_sel_q;
        end
        if (strobe_cnt_q == 16'h0001 && !strobe_sel_q) begin
          strobe_sel_q <= 1'b1;
          strobe_cnt_q <= strobe_width;
        end else begin
          strobe_cnt_q <= strobe_cnt_q - 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Motor
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MS_STOP = 2'b00,
    MS_CCW  = 2'b01,
    MS_CW   = 2'b11
  } motor_state_t;

  motor_state_t motor_q;
  logic [23:0]  step_tmr_q;
  logic [2:0]   step_idx_q;
  logic [23:0]  step_period;
  logic         half_step;
  logic [2:0]   cam_sync_q;
  logic         cam_q;

  // Rate and pattern by mode
  always_comb begin
    unique case (motor_mode)
      print_scan_pkg::MODE_SUPERFINE:  step_period = 24'(print_scan_pkg::STEP_108_CYC);
      print_scan_pkg::MODE_PAPER_FEED: step_period = 24'(print_scan_pkg::STEP_434_CYC);
      default:                         step_period = 24'(print_scan_pkg::STEP_217_CYC);
    endcase
    half_step = (motor_mode != print_scan_pkg::MODE_STD) &&
                (motor_mode != print_scan_pkg::MODE_PAPER_FEED);
  end

  // Cam switch from a pin: three stages, change taken when last two agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      cam_sync_q <= 3'h7;
      cam_q      <= 1'b1;
    end else begin
      cam_sync_q <= {cam_sync_q[1:0], cam_home_switch};
      if (cam_sync_q[2] == cam_sync_q[1]) cam_q <= cam_sync_q[2];
    end
  end
  assign cam_at_home = !cam_q;

  // Mode change: CCW until cam leaves home and returns, then CW
  logic left_home_q;
  always_ff @(posedge mclk) begin
    if (reset) begin
      motor_q     <= MS_STOP;
      left_home_q <= 1'b0;
    end else begin
      unique case (motor_q)
        MS_STOP: begin
          left_home_q <= 1'b0;
          if (mode_change)    motor_q <= MS_CCW;
          else if (motor_run) motor_q <= MS_CW;
        end
        MS_CCW: begin
          if (cam_q) left_home_q <= 1'b1;
          if (left_home_q && !cam_q) motor_q <= MS_CW;
        end
        MS_CW: begin
          if (!motor_run) motor_q <= MS_STOP;
        end
        default: motor_q <= MS_STOP;
      endcase
    end
  end

  // Step timing and phase index; direction picks index order
  always_ff @(posedge mclk) begin
    if (reset) begin
      step_tmr_q <= '0;
      step_idx_q <= '0;
    end else if (motor_q == MS_STOP) begin
      step_tmr_q <= '0;
    end else if (step_tmr_q == '0) begin
      step_tmr_q <= step_period - 1'b1;
      if (motor_q == MS_CCW) step_idx_q <= step_idx_q - (half_step ? 3'h1 : 3'h2);
      else                   step_idx_q <= step_idx_q + (half_step ? 3'h1 : 3'h2);
    end else begin
      step_tmr_q <= step_tmr_q - 1'b1;
    end
  end

  // Coil pattern; even indexes are two-coil states, odd single
  always_ff @(posedge mclk) begin
    if (reset) begin
      motor_phase        <= 4'h0;
      motor_power_enable <= 1'b0;
      motor_ccw          <= 1'b0;
    end else begin
      motor_power_enable <= (motor_q != MS_STOP);
      motor_ccw          <= (motor_q == MS_CCW);
      unique case ({step_idx_q[2:1], (step_idx_q[0] & half_step)})
        3'h0: motor_phase <= 4'h3;
        3'h1: motor_phase <= 4'h2;
        3'h2: motor_phase <= 4'h6;
        3'h3: motor_phase <= 4'h4;
        3'h4: motor_phase <= 4'hC;
        3'h5: motor_phase <= 4'h8;
        3'h6: motor_phase <= 4'h9;
        default: motor_phase <= 4'h1;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Scanner light and pitch (system domain)
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      scanner_light_enable <= 1'b0;
      scan_pitch_x100      <= 11'(print_scan_pkg::PITCH_STD_X100);
    end else begin
      if (original_inserted && start_request) scanner_light_enable <= 1'b1;
      else if (!scan_active)                  scanner_light_enable <= 1'b0;
      unique case (motor_mode)
        print_scan_pkg::MODE_STD:       scan_pitch_x100 <= 11'(print_scan_pkg::PITCH_STD_X100);
        print_scan_pkg::MODE_SUPERFINE: scan_pitch_x100 <= 11'(print_scan_pkg::PITCH_SF_X100);
        default:                        scan_pitch_x100 <= 11'(print_scan_pkg::PITCH_FINE_X100);
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Scanner link domain
  // ----------------------------------------------------------------
  logic [2:0]  scan_rst_sync_q;
  logic [2:0]  shade_sync_q;
  logic        scan_rst;
  logic        shade_mode;
  logic [7:0]  shading_mem [print_scan_pkg::DOTS_PER_LINE];
  logic [10:0] pix_cnt_q;
  logic [7:0]  sample_q;
  logic        sample_valid_q;
  logic [2:0]  drive_q;

  // Reset and shading level cross into the link clock
  always_ff @(posedge scan_clk) begin
    scan_rst_sync_q <= {scan_rst_sync_q[1:0], reset};
    shade_sync_q    <= {shade_sync_q[1:0], shading_capture};
  end
  assign scan_rst   = scan_rst_sync_q[2] & scan_rst_sync_q[1];
  assign shade_mode = shade_sync_q[2] & shade_sync_q[1];

  // Sample register, 8 bits per pixel
  always_ff @(posedge scan_clk) begin
    if (scan_rst) begin
      sample_q       <= 8'h00;
      sample_valid_q <= 1'b0;
      drive_q        <= 3'h1;
    end else begin
      sample_q       <= scanner_analog_input;
      sample_valid_q <= scanner_sample_valid;
      drive_q        <= {drive_q[1:0], drive_q[2]};
    end
  end
  assign sensor_drive_pulses = drive_q;

  // Shading store, then threshold at half the reference
  always_ff @(posedge scan_clk) begin
    if (sample_valid_q && shade_mode) shading_mem[pix_cnt_q] <= sample_q;
  end

  always_ff @(posedge scan_clk) begin
    if (scan_rst) begin
      pix_cnt_q      <= '0;
      scan_dot       <= 1'b0;
      scan_dot_valid <= 1'b0;
    end else begin
      scan_dot_valid <= sample_valid_q && !shade_mode;
      if (sample_valid_q) begin
        scan_dot  <= (sample_q < {1'b0, shading_mem[pix_cnt_q][7:1]});
        pix_cnt_q <= (pix_cnt_q == 11'(print_scan_pkg::DOTS_PER_LINE - 1)) ?
                     11'h000 : pix_cnt_q + 1'b1;
      end
    end
  end

endmodule // thermal_print_and_scan_drive

// ==== tb/head_chain_model.sv ====
// Behavioural model of the chained thermal head driver chips.
// Assumes head pins straight from the drive block, sampled on shift clock rise.
`timescale 1ns/1ps

module head_chain_model (
  input  wire logic          head_shift_clock,
  input  wire logic          head_serial_dot,
  input  wire logic          head_line_latch,
  input  wire logic          head_power_enable,
  input  wire logic          head_strobe_a,
  input  wire logic          head_strobe_b,
  output logic [1727:0]      latched_line,
  output logic               heating
);
  // ----------------------------------------------------------------
  // Shift chain and latch
  // ----------------------------------------------------------------
  logic [1727:0] chain_q;

  // Nine chips of 192 stages behave as one long chain
  always @(posedge head_shift_clock) begin
    chain_q <= {chain_q[1726:0], head_serial_dot};
  end

  // Whole chain copied at the latch, so the next line can shift meanwhile
  always @(posedge head_line_latch) begin
    latched_line <= chain_q;
  end

  // Only latched black elements heat, and only with supply present
  assign heating = head_power_enable && (head_strobe_a || head_strobe_b)
                   && (|latched_line);
endmodule // head_chain_model

// ==== tb/drive_assertions.sv ====
// Concurrent checks on the print and scan drive top level ports.
// Assumes binding onto thermal_print_and_scan_drive, mclk domain only.
`timescale 1ns/1ps

module drive_assertions (
  input wire logic        mclk,
  input wire logic        reset,
  input wire logic        head_shift_clock,
  input wire logic        head_serial_dot,
  input wire logic        head_line_latch,
  input wire logic        head_power_enable,
  input wire logic        head_strobe_a,
  input wire logic        head_strobe_b,
  input wire logic [10:0] scan_pitch_x100
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  // ----------------------------------------------------------------
  // Dot counter since the last latch
  // ----------------------------------------------------------------
  logic [11:0] rise_cnt_q;
  logic        shift_prev_q;

  // Counts shift clock rises; cleared by the latch itself
  always_ff @(posedge mclk) begin
    if (reset || head_line_latch) begin
      rise_cnt_q <= 12'h000;
    end else if (head_shift_clock && !shift_prev_q) begin
      rise_cnt_q <= rise_cnt_q + 12'h001;
    end
  end

  always_ff @(posedge mclk) begin
    shift_prev_q <= reset ? 1'b0 : head_shift_clock;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_latch_after_line: assert property ($rose(head_line_latch) |-> rise_cnt_q == 12'h6C0)
    else $error("latch not after a full line of dots");
  a_latch_width: assert property ($rose(head_line_latch) |-> head_line_latch [*4] ##1 !head_line_latch)
    else $error("latch pulse width wrong");
  a_shift_high_two: assert property ($rose(head_shift_clock) |-> ##1 head_shift_clock ##1 !head_shift_clock)
    else $error("shift clock high phase wrong");
  a_dot_stable_high: assert property (head_shift_clock |-> $stable(head_serial_dot))
    else $error("dot changed while shift clock high");
  a_no_latch_shift: assert property (head_line_latch |-> !head_shift_clock)
    else $error("latch during shifting");
  a_strobe_needs_power: assert property ((head_strobe_a || head_strobe_b) |-> head_power_enable)
    else $error("strobe without head power");
  a_strobe_not_latch: assert property (head_line_latch |-> !(head_strobe_a || head_strobe_b))
    else $error("strobe during latch");
  a_strobes_apart: assert property (!(head_strobe_a && head_strobe_b))
    else $error("both strobe groups at once");
  a_pitch_legal: assert property (scan_pitch_x100 inside {11'h166, 11'h302, 11'h604})
    else $error("illegal scan pitch");

  // Main scenarios reached
  c_latch: cover property ($rose(head_line_latch));
  c_strobe_a: cover property ($fell(head_strobe_a));
  c_strobe_b: cover property ($fell(head_strobe_b));
endmodule // drive_assertions

// ==== tb/testbench.sv ====
// Self-checking bench for the print and scan drive block.
// Assumes the head chain model and checker files are compiled before this one.
`timescale 1ns/1ps

module testbench;
  logic mclk, reset, print_dot, print_dot_valid, print_dot_ready, print_enable;
  logic [7:0] thermistor_code, scanner_analog_input;
  logic head_shift_clock, head_serial_dot, head_line_latch, head_power_enable;
  logic head_strobe_a, head_strobe_b, line_printed, motor_run, mode_change;
  logic cam_home_switch, motor_power_enable, motor_ccw, cam_at_home, scan_clk;
  logic original_inserted, start_request, scan_active, shading_capture;
  logic scanner_sample_valid, scanner_light_enable, scan_dot, scan_dot_valid;
  logic [2:0] motor_mode, sensor_drive_pulses;
  logic [3:0] motor_phase;
  logic [10:0] scan_pitch_x100;
  logic [1727:0] latched_line;
  logic heating;
  int fail_count = 0;
  int tests_run = 0;

  thermal_print_and_scan_drive i_dut (.*);
  head_chain_model i_head (.*);

  // ----------------------------------------------------------------
  // Clocks, unrelated in phase
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    scan_clk = 1'b0;
    #7;
    forever #16 scan_clk = ~scan_clk;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Dot pattern: black every fifth dot
  function automatic logic dot_of(input int i);
    return (i % 5) == 0;
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    chk("head_power", 16'h0000, {15'h0, head_power_enable});
    chk("strobes", 16'h0000, {14'h0, head_strobe_a, head_strobe_b});
    chk("motor_power", 16'h0000, {15'h0, motor_power_enable});
    chk("light", 16'h0000, {15'h0, scanner_light_enable});
    chk("pitch", 16'h0166, {5'h0, scan_pitch_x100});
    chk("cam_home", 16'h0000, {15'h0, cam_at_home});
  endtask

  task automatic t_pitch();
    logic [2:0]  modes [3] = '{print_scan_pkg::MODE_STD, print_scan_pkg::MODE_FINE,
                               print_scan_pkg::MODE_SUPERFINE};
    logic [15:0] pit [3] = '{16'h0166, 16'h0302, 16'h0604};
    for (int k = 0; k < 3; k++) begin
      motor_mode = modes[k];
      wait_cyc(4);
      chk("pitch_mode", pit[k], {5'h0, scan_pitch_x100});
    end
    motor_mode = print_scan_pkg::MODE_STD;
  endtask

  task automatic t_motor_cam();
    motor_run = 1'b1;
    wait_cyc(10);
    chk("motor_on", 16'h0001, {15'h0, motor_power_enable});
    chk("phase_first", 16'h0006, {12'h0, motor_phase});
    motor_run = 1'b0;
    wait_cyc(10);
    chk("motor_off", 16'h0000, {15'h0, motor_power_enable});
    cam_home_switch = 1'b0;
    wait_cyc(20);
    chk("cam_low_home", 16'h0001, {15'h0, cam_at_home});
    cam_home_switch = 1'b1;
    wait_cyc(20);
    chk("cam_high_away", 16'h0000, {15'h0, cam_at_home});
    mode_change = 1'b1;
    motor_run = 1'b1;
    wait_cyc(10);
    chk("ccw_first", 16'h0001, {15'h0, motor_ccw});
    chk("ccw_phase", 16'h0003, {12'h0, motor_phase});
    mode_change = 1'b0;
    cam_home_switch = 1'b0;
    wait_cyc(20);
    chk("cw_after_home", 16'h0000, {15'h0, motor_ccw});
    chk("motor_on_cw", 16'h0001, {15'h0, motor_power_enable});
    motor_run = 1'b0;
  endtask

  task automatic send_sample(input logic [7:0] s);
    @(negedge scan_clk);
    scanner_analog_input = s;
    scanner_sample_valid = 1'b1;
    @(negedge scan_clk);
    scanner_sample_valid = 1'b0;
  endtask

  task automatic scan_expect(input logic [7:0] s, input logic exp);
    send_sample(s);
    for (int k = 0; k < 8 && scan_dot_valid !== 1'b1; k++) @(negedge scan_clk);
    chk("scan_dot_valid", 16'h0001, {15'h0, scan_dot_valid});
    chk("scan_dot", {15'h0, exp}, {15'h0, scan_dot});
  endtask

  task automatic t_scan();
    original_inserted = 1'b1;
    start_request = 1'b1;
    wait_cyc(10);
    chk("light_on", 16'h0001, {15'h0, scanner_light_enable});
    scan_active = 1'b1;
    shading_capture = 1'b1;
    wait_cyc(4);
    for (int i = 0; i < 1728; i++) send_sample(8'h80);
    shading_capture = 1'b0;
    wait_cyc(10);
    // Reference 0x80 everywhere, so the threshold sits at 0x40
    scan_expect(8'h10, 1'b1);
    scan_expect(8'hF0, 1'b0);
    chk("sensor_onehot", 16'h0001, {15'h0, $onehot(sensor_drive_pulses)});
    chk("light_held", 16'h0001, {15'h0, scanner_light_enable});
    wait_cyc(1);
    scan_active = 1'b0;
    original_inserted = 1'b0;
    start_request = 1'b0;
    wait_cyc(4);
    chk("light_off", 16'h0000, {15'h0, scanner_light_enable});
  endtask

  task automatic push_dot(input logic d);
    print_dot = d;
    print_dot_valid = 1'b1;
    while (print_dot_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
  endtask

  task automatic t_print_line();
    int w = 0;
    thermistor_code = 8'hC0;
    // Head idle: the queue fills and then refuses
    for (int i = 0; i < 32; i++) push_dot(dot_of(i));
    chk("fifo_full", 16'h0000, {15'h0, print_dot_ready});
    chk("power_idle", 16'h0000, {15'h0, head_power_enable});
    print_enable = 1'b1;
    for (int i = 32; i < 1728; i++) push_dot(dot_of(i));
    print_dot_valid = 1'b0;
    while (head_line_latch !== 1'b1) @(negedge mclk);
    wait_cyc(5);
    chk("line_printed", 16'h0001, {15'h0, line_printed});
    wait_cyc(1);
    for (int i = 0; i < 1728; i += 7) begin
      chk("latched_dot", {15'h0, dot_of(i)}, {15'h0, latched_line[1727 - i]});
    end
    while (head_strobe_a !== 1'b1 && w < 400) begin
      @(negedge mclk);
      w++;
    end
    chk("heat_with_strobe", 16'h0001, {15'h0, heating});
    w = 0;
    while (head_strobe_a === 1'b1) begin
      @(negedge mclk);
      w++;
    end
    chk("strobe_width", 16'h1770, w[15:0]);
    print_enable = 1'b0;
    wait_cyc(14000);
    chk("power_after", 16'h0000, {15'h0, head_power_enable});
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {print_dot, print_dot_valid, print_enable, motor_run, mode_change} = 5'h00;
    {original_inserted, start_request, scan_active, shading_capture} = 4'h0;
    cam_home_switch = 1'b1;
    thermistor_code = 8'h00;
    motor_mode = 3'h0;
    scanner_analog_input = 8'h00;
    scanner_sample_valid = 1'b0;
    wait_cyc(10);
    reset = 1'b0;
    wait_cyc(2);
    t_reset_values();
    t_pitch();
    t_motor_cam();
    t_scan();
    t_print_line();
    final_report();
  end

  // Whole run needs about 30k cycles; allow twice that
  initial begin
    #3_000_000;
    fail_count++;
    final_report();
  end
endmodule // testbench

bind thermal_print_and_scan_drive drive_assertions i_chk (
  .mclk,
  .reset,
  .head_shift_clock,
  .head_serial_dot,
  .head_line_latch,
  .head_power_enable,
  .head_strobe_a,
  .head_strobe_b,
  .scan_pitch_x100
);
